// [dv/ccx_pin_src.sv]
`timescale 1ns/1ps
module ccx_pin_src (
    input  wire logic       clk_sys,
    input  wire logic [7:0] pulseReq,
    output logic      [1:0] pinLvl
);
    logic [7:0] done = 8'h0;
    logic [2:0] ph   = 3'h0;
    // 4 low, 4 high per pulse: wide enough for the synchroniser
    always @(posedge clk_sys) begin
        if (done != pulseReq || ph != 3'h0) begin
            ph <= ph + 3'h1;
            if (ph == 3'h7) begin
                done <= done + 8'h1;
            end
        end
    end
    // idle low, as with a pull-down on the line
    assign pinLvl = {2{ph[2]}};
endmodule : ccx_pin_src

// [dv/ccx_properties.sv]
`timescale 1ns/1ps
module ccx_properties
    import ccx_pkg::*;
(
    input wire logic                 clk_sys,
    input wire logic                 rst,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_we_i,
    input wire logic [CCX_ADR_W-1:0] wb_adr_i,
    input wire logic [31:0]          wb_dat_o,
    input wire logic                 wb_ack_o,
    input wire logic                 auxTimerIrq,
    input wire logic                 secondaryOscRun,
    input wire logic                 specialEventPulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // request the slave has not yet answered
    logic req, rd, wr;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd  = req && !wb_we_i;
    assign wr  = req && wb_we_i;
    AST_ACK_NEXT: assert property (req |=> wb_ack_o) else $error("ack late");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(req)) else $error("stray ack");
    AST_CTL_TOP: assert property (wb_ack_o && $past(rd && wb_adr_i == CCX_OFS_U1CTL)
        |-> wb_dat_o[7:6] == 2'h0) else $error("ctl top bits");
    AST_FLG_TOP: assert property (wb_ack_o && $past(rd && wb_adr_i == CCX_OFS_FLAGS2)
        |-> wb_dat_o[31:5] == 27'h0) else $error("flag top bits");
    AST_IRQ_EN: assert property (wb_ack_o && $past(rd && wb_adr_i == CCX_OFS_ENA2)
        && !wb_dat_o[CCX_OVF_BIT] |-> !auxTimerIrq) else $error("irq while off");
    AST_OSC_SRC: assert property ($changed(secondaryOscRun)
        |-> $past(wr && wb_adr_i == CCX_OFS_T1CTL)
        || $past(wr && wb_adr_i == CCX_OFS_T1CTL, 2)) else $error("osc moved");
    AST_SEP_ONE: assert property (specialEventPulse |=> !specialEventPulse)
        else $error("event held");
endmodule : ccx_properties

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import ccx_pkg::*;
    logic        clk_sys = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0, extClkPin = 1'b0;
    logic [7:0]  wb_adr_i = 8'h0, pulseReq = 8'h0, q, v;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic [1:0]  unitPinIn, unitPinOut, unitPinOe;
    logic        wb_ack_o, auxTimerIrq, secondaryOscRun, specialEventPulse;
    int          fails = 0, checks = 0, seed = 82793, n;
    // reset model: offsets and values, last one unmapped
    logic [7:0]  ofs[$] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'hfc};
    int          rstv[$] = '{0, 0, 'h1f, 0, 0, 0, 0, 0, 0};
    always #5 clk_sys = ~clk_sys;
    ccx_top uut (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .extClkPin, .unitPinIn, .unitPinOut,
        .unitPinOe, .auxTimerIrq, .secondaryOscRun, .specialEventPulse);
    ccx_pin_src src (.clk_sys, .pulseReq, .pinLvl(unitPinIn));
    task automatic complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one classic cycle; waits for ack with a bound, then leaves a gap
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys);
        if (n >= 20) begin fails++; complete_run(); end
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, e);
    endtask : rd
    // edges from one event pulse to the next, bounded
    task automatic waitp;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (specialEventPulse !== 1'b1 && n < 200);
        if (n >= 200) begin fails++; complete_run(); end
    endtask : waitp
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        foreach (ofs[i]) rd(ofs[i], 8'(rstv[i]));
        repeat (4) begin
            v = 8'($random(seed));
            bus(1'b1, CCX_OFS_T1CTL, v);
            rd(CCX_OFS_T1CTL, v & CCX_T1CTL_MASK);
            chk({7'h0, secondaryOscRun}, {7'h0, v[3]});
            bus(1'b1, CCX_OFS_U2CTL, v);
            rd(CCX_OFS_U2CTL, v & 8'h3f);
        end
        bus(1'b1, CCX_OFS_U2CTL, 8'h00);
        // wrap from fff0: 16 ticks at prescale 1
        bus(1'b1, CCX_OFS_CNT_HI, 8'hff);
        bus(1'b1, CCX_OFS_CNT_LO, 8'hf0);
        bus(1'b1, CCX_OFS_ENA2, 8'h02);
        bus(1'b1, CCX_OFS_AUXCTL, 8'h01);
        repeat (20) @(posedge clk_sys);
        rd(CCX_OFS_FLAGS2, 8'h02);
        chk({7'h0, auxTimerIrq}, 8'h01);
        rd(CCX_OFS_CNT_HI, 8'h00);
        bus(1'b1, CCX_OFS_ENA2, 8'h00);
        chk({7'h0, auxTimerIrq}, 8'h00);
        bus(1'b1, CCX_OFS_FLAGS2, 8'h00);
        // period of 0x20 gives 33 ticks between events
        bus(1'b1, CCX_OFS_U1VLO, 8'h20);
        bus(1'b1, CCX_OFS_U1CTL, 8'h0b);
        bus(1'b1, CCX_OFS_CNT_LO, 8'h00);
        waitp();
        waitp();
        chk(8'(n), 8'd33);
        rd(CCX_OFS_FLAGS2, 8'h00);
        rd(CCX_OFS_U1STAT, 8'h01);
        bus(1'b1, CCX_OFS_U1CTL, 8'h00);
        // every 4th rise: three pulses leave the flag clear
        bus(1'b1, CCX_OFS_U2CTL, 8'h06);
        pulseReq <= pulseReq + 8'd3;
        repeat (40) @(posedge clk_sys);
        rd(CCX_OFS_FLAGS2, 8'h00);
        // timer parked at 005a so the captured value is known
        bus(1'b1, CCX_OFS_AUXCTL, 8'h00);
        bus(1'b1, CCX_OFS_CNT_LO, 8'h5a);
        pulseReq <= pulseReq + 8'd1;
        repeat (16) @(posedge clk_sys);
        rd(CCX_OFS_FLAGS2, 8'h01);
        rd(CCX_OFS_U2VLO, 8'h5a);
        bus(1'b1, CCX_OFS_AUXCTL, 8'h01);
        // preset then force: oe high, pin flips at match with 0x40
        bus(1'b1, CCX_OFS_U2VLO, 8'h40);
        for (int m = 8; m < 10; m++) begin
            bus(1'b1, CCX_OFS_U2CTL, 8'(m));
            chk({7'h0, unitPinOut[1]}, 8'(m - 8));
            bus(1'b1, CCX_OFS_CNT_HI, 8'h00);
            bus(1'b1, CCX_OFS_CNT_LO, 8'h00);
            repeat (80) @(posedge clk_sys);
            chk({unitPinOe[1], 6'h0, unitPinOut[1]}, 8'(137 - m));
        end
        // toggle lifts the low pin, flag-only mode must leave it high
        for (int m = 2; m < 11; m += 8) begin
            bus(1'b1, CCX_OFS_U2CTL, 8'(m));
            bus(1'b1, CCX_OFS_CNT_LO, 8'h00);
            repeat (80) @(posedge clk_sys);
            chk({unitPinOe[1], 6'h0, unitPinOut[1]}, 8'h81);
        end
        // disable drops both pin and enable
        bus(1'b1, CCX_OFS_U2CTL, 8'h00);
        chk({unitPinOe[1], 6'h0, unitPinOut[1]}, 8'h00);
        // falling-edge capture sets the unit two flag again
        bus(1'b1, CCX_OFS_FLAGS2, 8'h00);
        bus(1'b1, CCX_OFS_U2CTL, 8'h04);
        pulseReq <= pulseReq + 8'd1;
        repeat (16) @(posedge clk_sys);
        rd(CCX_OFS_FLAGS2, 8'h01);
        complete_run();
    end
endmodule : testbench
bind ccx_top ccx_properties chk_i (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .auxTimerIrq, .secondaryOscRun, .specialEventPulse);

// [rtl/ccx_pkg.sv]
// Functional notes
// - aux timer counts 0000h to ffffh, wraps
// - wrap latches overflow flag, flags-two bit 1
// - overflow request only while enable bit set
// - unit one special-event match clears timer
// - special-event clear never sets overflow flag
// - timer write beats coincident special-event clear
// - unit one value is timer period there
// - secondary oscillator runs only while enabled
// - one 16-bit value per unit, mode-dependent
// - unit two identical, no special-event clear
// - control bits 7-6 read as zero
// - PWM duty is 10 bits, low two from control
// - mode 0000 disables, resets unit state
// - mode 0010 toggles pin, sets match flag
// - capture on fall, rise, 4th, 16th rise
// - modes 1000/1001 preset pin, force on match
// - mode 1010 only flags, pin untouched
// - mode 1011 flags and pulses special event
package ccx_pkg;

    localparam int CCX_UNITS = 2;
    localparam int CCX_ADR_W = 8;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CCX_OFS_FLAGS2  = 8'h00;
    localparam logic [7:0] CCX_OFS_ENA2    = 8'h04;
    localparam logic [7:0] CCX_OFS_PRIO2   = 8'h08;
    localparam logic [7:0] CCX_OFS_CNT_LO  = 8'h0c;
    localparam logic [7:0] CCX_OFS_CNT_HI  = 8'h10;
    localparam logic [7:0] CCX_OFS_T1CTL   = 8'h14;
    localparam logic [7:0] CCX_OFS_AUXCTL  = 8'h18;
    localparam logic [7:0] CCX_OFS_U1CTL   = 8'h1c;
    localparam logic [7:0] CCX_OFS_U1VLO   = 8'h20;
    localparam logic [7:0] CCX_OFS_U1VHI   = 8'h24;
    localparam logic [7:0] CCX_OFS_U2CTL   = 8'h28;
    localparam logic [7:0] CCX_OFS_U2VLO   = 8'h2c;
    localparam logic [7:0] CCX_OFS_U2VHI   = 8'h30;
    localparam logic [7:0] CCX_OFS_U1STAT  = 8'h34;

    // ------------------------------------------------------------------
    // reset values and implemented-bit masks
    // ------------------------------------------------------------------
    localparam logic [7:0]  CCX_FLAGS2_RST = 8'h00;
    localparam logic [7:0]  CCX_ENA2_RST   = 8'h00;
    localparam logic [7:0]  CCX_PRIO2_RST  = 8'h1f;
    localparam logic [7:0]  CCX_T1CTL_RST  = 8'h00;
    localparam logic [7:0]  CCX_AUXCTL_RST = 8'h00;
    localparam logic [15:0] CCX_CNT_RST    = 16'h0000;
    localparam logic [15:0] CCX_VAL_RST    = 16'h0000;
    localparam logic [15:0] CCX_CNT_MAX    = 16'hffff;
    localparam logic [7:0]  CCX_IRQ5_MASK  = 8'h1f;
    localparam logic [7:0]  CCX_T1CTL_MASK = 8'hbf;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CCX_OVF_BIT    = 1;
    localparam int CCX_U2FLAG_BIT = 0;
    localparam int CCX_U1FLAG_BIT = 0;
    localparam int CCX_OSCEN_BIT  = 3;
    localparam int CCX_AUXON_BIT  = 0;
    localparam int CCX_AUXEXT_BIT = 1;
    localparam int CCX_AUXPS_LSB  = 4;

    // capture prescale terminal counts
    localparam logic [3:0] CCX_CAP_LIM4  = 4'h3;
    localparam logic [3:0] CCX_CAP_LIM16 = 4'hf;

    typedef enum logic [3:0] {
        CCX_M_OFF      = 4'b0000,
        CCX_M_RSV1     = 4'b0001,
        CCX_M_TOGGLE   = 4'b0010,
        CCX_M_RSV3     = 4'b0011,
        CCX_M_CAP_FALL = 4'b0100,
        CCX_M_CAP_RISE = 4'b0101,
        CCX_M_CAP_R4   = 4'b0110,
        CCX_M_CAP_R16  = 4'b0111,
        CCX_M_CMP_HI   = 4'b1000,
        CCX_M_CMP_LO   = 4'b1001,
        CCX_M_CMP_SOFT = 4'b1010,
        CCX_M_CMP_SPEC = 4'b1011,
        CCX_M_PWM0     = 4'b1100,
        CCX_M_PWM1     = 4'b1101,
        CCX_M_PWM2     = 4'b1110,
        CCX_M_PWM3     = 4'b1111
    } ccx_mode_e;

    typedef struct packed {
        logic [1:0] dutyLow;
        ccx_mode_e  mode;
    } ccx_unit_ctl_s;

    localparam ccx_unit_ctl_s CCX_CTL_RST = '{dutyLow: 2'h0, mode: CCX_M_OFF};

endpackage : ccx_pkg

// [rtl/ccx_top.sv]
`timescale 1ns/1ps
module ccx_top
    import ccx_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // classic wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [CCX_ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // pins
    input  wire logic                  extClkPin,
    input  wire logic [CCX_UNITS-1:0]  unitPinIn,
    output logic      [CCX_UNITS-1:0]  unitPinOut,
    output logic      [CCX_UNITS-1:0]  unitPinOe,
    // system side
    output logic                       auxTimerIrq,
    output logic                       secondaryOscRun,
    output logic                       specialEventPulse
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]          flagsTwo;
    logic [7:0]          enablesTwo;
    logic [7:0]          priorityTwo;
    logic [7:0]          firstTimerCtl;
    logic [7:0]          auxCtl;
    logic [15:0]         auxCount;
    logic [2:0]          preCount;
    logic                unitOneFlag;
    ccx_unit_ctl_s       unitCtl   [CCX_UNITS];
    logic [15:0]         unitVal   [CCX_UNITS];
    logic [3:0]          capCount  [CCX_UNITS];
    logic [CCX_UNITS-1:0] pinMeta;
    logic [CCX_UNITS-1:0] pinSync;
    logic [CCX_UNITS-1:0] pinPrev;
    logic                extMeta;
    logic                extSync;
    logic                extPrev;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic                accept;
    logic                wrEn;
    logic [7:0]          wrByte;
    logic [7:0]          wordAdr;

    // access taken on the first cycle of a strobe, answered next cycle
    assign accept  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wrEn    = accept & wb_we_i & wb_sel_i[0];
    assign wrByte  = wb_dat_i[7:0];
    assign wordAdr = {wb_adr_i[CCX_ADR_W-1:2], 2'b00};

    logic wrFlags2;
    logic wrEna2;
    logic wrPrio2;
    logic wrCntLo;
    logic wrCntHi;
    logic wrT1;
    logic wrAux;
    logic wrU1Stat;
    logic [CCX_UNITS-1:0] wrCtl;
    logic [CCX_UNITS-1:0] wrVLo;
    logic [CCX_UNITS-1:0] wrVHi;

    // per-register write strobes
    assign wrFlags2 = wrEn & (wordAdr == CCX_OFS_FLAGS2);
    assign wrEna2   = wrEn & (wordAdr == CCX_OFS_ENA2);
    assign wrPrio2  = wrEn & (wordAdr == CCX_OFS_PRIO2);
    assign wrCntLo  = wrEn & (wordAdr == CCX_OFS_CNT_LO);
    assign wrCntHi  = wrEn & (wordAdr == CCX_OFS_CNT_HI);
    assign wrT1     = wrEn & (wordAdr == CCX_OFS_T1CTL);
    assign wrAux    = wrEn & (wordAdr == CCX_OFS_AUXCTL);
    assign wrU1Stat = wrEn & (wordAdr == CCX_OFS_U1STAT);
    assign wrCtl    = {wrEn & (wordAdr == CCX_OFS_U2CTL), wrEn & (wordAdr == CCX_OFS_U1CTL)};
    assign wrVLo    = {wrEn & (wordAdr == CCX_OFS_U2VLO), wrEn & (wordAdr == CCX_OFS_U1VLO)};
    assign wrVHi    = {wrEn & (wordAdr == CCX_OFS_U2VHI), wrEn & (wordAdr == CCX_OFS_U1VHI)};

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // the second and third stages feed edge detection
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pinMeta <= '0;
            pinSync <= '0;
            pinPrev <= '0;
            extMeta <= 1'b0;
            extSync <= 1'b0;
            extPrev <= 1'b0;
        end else begin
            pinMeta <= unitPinIn;
            pinSync <= pinMeta;
            pinPrev <= pinSync;
            extMeta <= extClkPin;
            extSync <= extMeta;
            extPrev <= extSync;
        end
    end

    // ------------------------------------------------------------------
    // aux timer increment enable
    // ------------------------------------------------------------------
    logic       auxOn;
    logic       srcEvent;
    logic [2:0] preLimit;
    logic       tick;

    // external source counts sampled rising edges; async mode is treated
    // as synchronised, so the special-event clear always works here
    assign auxOn    = auxCtl[CCX_AUXON_BIT];
    assign srcEvent = auxCtl[CCX_AUXEXT_BIT] ? (extSync & ~extPrev) : 1'b1;
    assign preLimit = 3'((4'h1 << auxCtl[CCX_AUXPS_LSB +: 2]) - 4'h1);
    assign tick     = auxOn & srcEvent & (preCount == preLimit);

    // prescaler 1:1, 1:2, 1:4, 1:8
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            preCount <= 3'h0;
        end else if (!auxOn || wrAux) begin
            preCount <= 3'h0;
        end else if (srcEvent) begin
            preCount <= (preCount == preLimit) ? 3'h0 : 3'(preCount + 3'h1);
        end
    end

    // ------------------------------------------------------------------
    // compare match and special event
    // ------------------------------------------------------------------
    logic [CCX_UNITS-1:0] match;
    logic                 specialClear;
    logic                 cntWrite;
    logic                 wrapEvent;

    // match sampled only on an increment, count equal to value
    always_comb begin
        for (int i = 0; i < CCX_UNITS; i++) begin
            match[i] = tick & (auxCount == unitVal[i]);
        end
    end

    // only unit one may clear the timer
    assign specialClear = match[0] & (unitCtl[0].mode == CCX_M_CMP_SPEC);
    assign cntWrite     = wrCntLo | wrCntHi;
    // a clear or a write is never a wrap
    assign wrapEvent    = tick & (auxCount == CCX_CNT_MAX) & ~specialClear & ~cntWrite;

    // ------------------------------------------------------------------
    // aux timer count pair
    // ------------------------------------------------------------------
    // write wins over clear and increment clear makes value the
    // period, counting 0..value then 0 again
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            auxCount <= CCX_CNT_RST;
        end else if (cntWrite) begin
            if (wrCntLo) begin
                auxCount[7:0] <= wrByte;
            end
            if (wrCntHi) begin
                auxCount[15:8] <= wrByte;
            end
        end else if (specialClear) begin
            auxCount <= CCX_CNT_RST;
        end else if (tick) begin
            auxCount <= 16'(auxCount + 16'h0001);
        end
    end

    // ------------------------------------------------------------------
    // unit event flags
    // ------------------------------------------------------------------
    logic [CCX_UNITS-1:0] capEvent;
    logic [CCX_UNITS-1:0] unitEvent;
    logic [7:0]           flagSet;

    // a flag is set by capture or by match in any compare mode
    always_comb begin
        for (int i = 0; i < CCX_UNITS; i++) begin
            unitEvent[i] = capEvent[i];
            case (unitCtl[i].mode)
                CCX_M_TOGGLE,
                CCX_M_CMP_HI,
                CCX_M_CMP_LO,
                CCX_M_CMP_SOFT,
                CCX_M_CMP_SPEC:
                    unitEvent[i] = match[i];
                default:
                    unitEvent[i] = capEvent[i];
            endcase
        end
        flagSet = 8'h00;
        flagSet[CCX_OVF_BIT]    = wrapEvent;
        flagSet[CCX_U2FLAG_BIT] = unitEvent[1];
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flagsTwo    <= CCX_FLAGS2_RST;
            unitOneFlag <= 1'b0;
        end else begin
            if (wrFlags2) begin
                flagsTwo <= (wrByte & CCX_IRQ5_MASK) | flagSet;
            end else begin
                flagsTwo <= flagsTwo | flagSet;
            end
            if (wrU1Stat) begin
                unitOneFlag <= wrByte[CCX_U1FLAG_BIT] | unitEvent[0];
            end else begin
                unitOneFlag <= unitOneFlag | unitEvent[0];
            end
        end
    end

    // ------------------------------------------------------------------
    // plain control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enablesTwo    <= CCX_ENA2_RST;
            priorityTwo   <= CCX_PRIO2_RST;
            firstTimerCtl <= CCX_T1CTL_RST;
            auxCtl        <= CCX_AUXCTL_RST;
        end else begin
            if (wrEna2) begin
                enablesTwo <= wrByte & CCX_IRQ5_MASK;
            end
            if (wrPrio2) begin
                priorityTwo <= wrByte & CCX_IRQ5_MASK;
            end
            if (wrT1) begin
                firstTimerCtl <= wrByte & CCX_T1CTL_MASK;
            end
            if (wrAux) begin
                auxCtl <= wrByte;
            end
        end
    end

    // ------------------------------------------------------------------
    // capture/compare units
    // ------------------------------------------------------------------
    logic [CCX_UNITS-1:0] rise;
    logic [CCX_UNITS-1:0] fall;

    assign rise = pinSync & ~pinPrev;
    assign fall = ~pinSync & pinPrev;

    // capture qualification per mode
    always_comb begin
        for (int i = 0; i < CCX_UNITS; i++) begin
            case (unitCtl[i].mode)
                CCX_M_CAP_FALL: capEvent[i] = fall[i];
                CCX_M_CAP_RISE: capEvent[i] = rise[i];
                CCX_M_CAP_R4:   capEvent[i] = rise[i] & (capCount[i] == CCX_CAP_LIM4);
                CCX_M_CAP_R16:  capEvent[i] = rise[i] & (capCount[i] == CCX_CAP_LIM16);
                default:        capEvent[i] = 1'b0;
            endcase
        end
    end

    // control, bits 7-6 not stored capture prescaler restarts on
    // any control write and in mode 0000
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < CCX_UNITS; i++) begin
                unitCtl[i]  <= CCX_CTL_RST;
                capCount[i] <= 4'h0;
            end
        end else begin
            for (int i = 0; i < CCX_UNITS; i++) begin
                if (wrCtl[i]) begin
                    unitCtl[i]  <= ccx_unit_ctl_s'(wrByte[5:0]);
                    capCount[i] <= 4'h0;
                end else if (unitCtl[i].mode == CCX_M_OFF) begin
                    capCount[i] <= 4'h0;
                end else if (rise[i] && unitCtl[i].mode == CCX_M_CAP_R4) begin
                    capCount[i] <= (capCount[i] == CCX_CAP_LIM4) ? 4'h0 : 4'(capCount[i] + 4'h1);
                end else if (rise[i] && unitCtl[i].mode == CCX_M_CAP_R16) begin
                    capCount[i] <= 4'(capCount[i] + 4'h1);
                end
            end
        end
    end

    // value pair: capture target, compare value or duty a capture
    // beats a software write of the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < CCX_UNITS; i++) begin
                unitVal[i] <= CCX_VAL_RST;
            end
        end else begin
            for (int i = 0; i < CCX_UNITS; i++) begin
                if (capEvent[i]) begin
                    unitVal[i] <= auxCount;
                end else begin
                    if (wrVLo[i]) begin
                        unitVal[i][7:0] <= wrByte;
                    end
                    if (wrVHi[i]) begin
                        unitVal[i][15:8] <= wrByte;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // unit pin drive
    // ------------------------------------------------------------------
    logic [9:0] duty [CCX_UNITS];

    // ten-bit duty: byte above, two control bits below
    always_comb begin
        for (int i = 0; i < CCX_UNITS; i++) begin
            duty[i] = {unitVal[i][7:0], unitCtl[i].dutyLow};
        end
    end

    // setup level on a control write, then per-mode match action; PWM
    // ramps on the low ten timer bits since no period timer lives here
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            unitPinOut <= '0;
            unitPinOe  <= '0;
        end else begin
            for (int i = 0; i < CCX_UNITS; i++) begin
                if (wrCtl[i]) begin
                    case (wrByte[3:0])
                        CCX_M_CMP_HI: unitPinOut[i] <= 1'b0;
                        CCX_M_CMP_LO: unitPinOut[i] <= 1'b1;
                        CCX_M_OFF:    unitPinOut[i] <= 1'b0;
                        default:      unitPinOut[i] <= unitPinOut[i];
                    endcase
                end else begin
                    case (unitCtl[i].mode)
                        CCX_M_TOGGLE: if (match[i]) unitPinOut[i] <= ~unitPinOut[i];
                        CCX_M_CMP_HI: if (match[i]) unitPinOut[i] <= 1'b1;
                        CCX_M_CMP_LO: if (match[i]) unitPinOut[i] <= 1'b0;
                        CCX_M_PWM0, CCX_M_PWM1, CCX_M_PWM2, CCX_M_PWM3:
                            unitPinOut[i] <= (auxCount[9:0] < duty[i]);
                        default:      unitPinOut[i] <= unitPinOut[i];
                    endcase
                end
                case (unitCtl[i].mode)
                    CCX_M_TOGGLE, CCX_M_CMP_HI, CCX_M_CMP_LO,
                    CCX_M_CMP_SOFT, CCX_M_CMP_SPEC,
                    CCX_M_PWM0, CCX_M_PWM1, CCX_M_PWM2, CCX_M_PWM3:
                        unitPinOe[i] <= 1'b1;
                    default:
                        unitPinOe[i] <= 1'b0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // system outputs
    // ------------------------------------------------------------------
    // request gated by enable oscillator follows its enable
    // special event pulse one cycle after the match
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            auxTimerIrq       <= 1'b0;
            secondaryOscRun   <= 1'b0;
            specialEventPulse <= 1'b0;
        end else begin
            auxTimerIrq       <= flagsTwo[CCX_OVF_BIT] & enablesTwo[CCX_OVF_BIT];
            secondaryOscRun   <= firstTimerCtl[CCX_OSCEN_BIT];
            specialEventPulse <= specialClear;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    logic [7:0] rdByte;

    // unmapped words read zero
    always_comb begin
        case (wordAdr)
            CCX_OFS_FLAGS2: rdByte = flagsTwo;
            CCX_OFS_ENA2:   rdByte = enablesTwo;
            CCX_OFS_PRIO2:  rdByte = priorityTwo;
            CCX_OFS_CNT_LO: rdByte = auxCount[7:0];
            CCX_OFS_CNT_HI: rdByte = auxCount[15:8];
            CCX_OFS_T1CTL:  rdByte = firstTimerCtl;
            CCX_OFS_AUXCTL: rdByte = auxCtl;
            CCX_OFS_U1CTL:  rdByte = {2'b00, unitCtl[0]};
            CCX_OFS_U1VLO:  rdByte = unitVal[0][7:0];
            CCX_OFS_U1VHI:  rdByte = unitVal[0][15:8];
            CCX_OFS_U2CTL:  rdByte = {2'b00, unitCtl[1]};
            CCX_OFS_U2VLO:  rdByte = unitVal[1][7:0];
            CCX_OFS_U2VHI:  rdByte = unitVal[1][15:8];
            CCX_OFS_U1STAT: rdByte = {7'h00, unitOneFlag};
            default:        rdByte = 8'h00;
        endcase
    end

    // single-cycle ack, data registered alongside it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= accept;
            if (accept && !wb_we_i) begin
                wb_dat_o <= {24'h00_0000, rdByte};
            end
        end
    end

endmodule : ccx_top
